// File: design/router_pkg.sv
// Constants and types for the logical signal router
package router_pkg;

	// ==========================================================
	// Signal states
	typedef enum logic [1:0] {
		ST_VALID   = 2'h0,
		ST_SPECIAL = 2'h1,
		ST_ERROR   = 2'h2,
		ST_NA      = 2'h3
	} sig_state_t;

	// ==========================================================
	// Widths and reset values
	localparam int          FRAC_W      = 16;
	localparam int          RAW_W       = 16;
	localparam int          CODE_W      = 32;
	localparam int          DIV_CYCLES  = FRAC_W;
	localparam logic [31:0] CODE_ZERO   = 32'h0000_0000;
	localparam logic [31:0] CODE_RST    = 32'h0000_0000;
	localparam logic [15:0] HALF_VAL    = 16'h8000;
	localparam logic [15:0] ONE_VAL     = 16'hFFFF;

	// ==========================================================
	// Register map
	localparam logic [7:0] ADDR_CTRL    = 8'h00;
	localparam logic [7:0] ADDR_STATUS  = 8'h01;
	localparam logic [7:0] ADDR_IRQ_ST  = 8'h02;
	localparam logic [7:0] ADDR_IRQ_MSK = 8'h03;
	localparam logic [7:0] ADDR_PROD_B  = 8'h10;
	localparam logic [7:0] ADDR_CONS_B  = 8'h40;
	localparam logic [7:0] ADDR_RES_B   = 8'h80;
	localparam logic [7:0] ADDR_RST_B   = 8'hC0;
	localparam int         IRQ_W        = 2;
	localparam int         IRQ_NORM_DONE = 0;
	localparam int         IRQ_INPUT_ERR = 1;
	localparam int         CONS_SEL_LSB = 0;
	localparam int         CONS_INV_BIT = 8;
	localparam int         CONS_DISC_BIT = 9;
	localparam logic [7:0] SEL_NONE     = 8'h00;
	localparam logic [31:0] RST_ZERO    = 32'h0000_0000;

endpackage

// File: design/signal_router.sv
// Logical signal router with normalization, threshold and inversion
//
// Design decisions made here: strobed register access and the address map.
`timescale 1ns/1ps
`default_nettype none
module signal_router
	import router_pkg::*;
#(
	parameter int N_PROD = 4,
	parameter int N_CONS = 4
) (
	// Clock and reset
	input  wire logic                       mclk_in,
	input  wire logic                       sys_rst_in,
	input  wire logic                       clk_en_in,
	// Producer side, same clock
	input  wire logic [N_PROD*RAW_W-1:0]    prod_raw_in,
	input  wire logic [N_PROD-1:0]          prod_disc_in,
	input  wire logic [N_PROD*2-1:0]        prod_state_in,
	input  wire logic [N_PROD*CODE_W-1:0]   prod_code_in,
	// Consumer side
	output logic      [N_CONS*FRAC_W-1:0]   normalized_input_out,
	output logic      [N_CONS*RAW_W-1:0]    cons_value_out,
	output logic      [N_CONS-1:0]          cons_bit_out,
	output logic      [N_CONS*2-1:0]        cons_state_out,
	output logic      [N_CONS*CODE_W-1:0]   cons_code_out,
	// Register port
	input  wire logic [7:0]                 reg_addr_in,
	input  wire logic [31:0]                reg_wdata_in,
	input  wire logic                       reg_wr_in,
	input  wire logic                       reg_rd_in,
	output logic      [31:0]                reg_rdata_out,
	// Interrupt
	output logic                            irq_out
);
	default clocking @(posedge mclk_in); endclocking
	default disable iff (sys_rst_in);

	// ==========================================================
	// Configuration registers
	logic [RAW_W-1:0]  pmin_q [N_PROD];
	logic [RAW_W-1:0]  pmax_q [N_PROD];
	logic [7:0]        csel_q [N_CONS];
	logic              cinv_q [N_CONS];
	logic              cdisc_q [N_CONS];
	logic [RAW_W-1:0]  cmin_q [N_CONS];
	logic [RAW_W-1:0]  cmax_q [N_CONS];
	logic [IRQ_W-1:0]  irq_st_q, irq_st_d, irq_msk_q;
	logic [31:0]       rdata_q, rdata_d;
	logic              irq_q;

	function automatic logic hit(input logic [7:0] a, input logic [7:0] base, input int idx);
		hit = (a == 8'(int'(base) + idx));
	endfunction

	// ==========================================================
	// Normalization: sequential divider across producers
	typedef enum logic [2:0] {
		S_IDLE = 3'b001,
		S_DIV  = 3'b010,
		S_NEXT = 3'b100
	} div_state_t;

	div_state_t          st_q, st_d;
	logic [7:0]          pidx_q, pidx_d;
	logic [4:0]          bit_q, bit_d;
	logic [RAW_W:0]      rem_q, rem_d;
	logic [FRAC_W-1:0]   quo_q, quo_d;
	logic [FRAC_W-1:0]   norm_q [N_PROD];
	logic [FRAC_W-1:0]   norm_d [N_PROD];
	logic                nerr_q [N_PROD];
	logic                nerr_d [N_PROD];
	logic                round_done;

	logic [RAW_W-1:0] cur_raw, cur_min, cur_span;
	assign cur_raw  = prod_raw_in[pidx_q[1:0]*RAW_W +: RAW_W];
	assign cur_min  = pmin_q[pidx_q[1:0]];
	assign cur_span = pmax_q[pidx_q[1:0]] - pmin_q[pidx_q[1:0]];

	always_comb begin
		st_d = st_q;
		pidx_d = pidx_q;
		bit_d = bit_q;
		rem_d = rem_q;
		quo_d = quo_q;
		norm_d = norm_q;
		nerr_d = nerr_q;
		round_done = 1'b0;
		unique case (st_q)
			S_IDLE: begin
				// Clamp then start a fraction division of (raw-min)/span
				if (cur_raw <= cur_min)
					rem_d = '0;
				else if (cur_raw >= pmax_q[pidx_q[1:0]])
					rem_d = {1'b0, cur_span};
				else
					rem_d = {1'b0, cur_raw - cur_min};
				quo_d = '0;
				bit_d = 5'(DIV_CYCLES);
				st_d = S_DIV;
			end
			S_DIV: begin
				if (cur_span == '0) begin
					nerr_d[pidx_q[1:0]] = 1'b1;
					norm_d[pidx_q[1:0]] = '0;
					st_d = S_NEXT;
				end else if (rem_q[RAW_W-1:0] == cur_span && bit_q == 5'(DIV_CYCLES)) begin
					norm_d[pidx_q[1:0]] = ONE_VAL;
					nerr_d[pidx_q[1:0]] = 1'b0;
					st_d = S_NEXT;
				end else if (bit_q == 5'h0) begin
					norm_d[pidx_q[1:0]] = quo_q;
					nerr_d[pidx_q[1:0]] = 1'b0;
					st_d = S_NEXT;
				end else begin
					if ({rem_q[RAW_W-1:0], 1'b0} >= {1'b0, cur_span}) begin
						rem_d = {rem_q[RAW_W-1:0], 1'b0} - {1'b0, cur_span};
						quo_d = {quo_q[FRAC_W-2:0], 1'b1};
					end else begin
						rem_d = {rem_q[RAW_W-1:0], 1'b0};
						quo_d = {quo_q[FRAC_W-2:0], 1'b0};
					end
					bit_d = bit_q - 5'h1;
				end
			end
			S_NEXT: begin
				if (pidx_q == 8'(N_PROD - 1)) begin
					pidx_d = '0;
					round_done = 1'b1;
				end else begin
					pidx_d = pidx_q + 8'h1;
				end
				st_d = S_IDLE;
			end
		endcase
	end

	always_ff @(posedge mclk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			st_q <= S_IDLE;
			pidx_q <= '0;
			bit_q <= '0;
			rem_q <= '0;
			quo_q <= '0;
			norm_q <= '{default: '0};
			nerr_q <= '{default: 1'b0};
		end else if (clk_en_in) begin
			st_q <= st_d;
			pidx_q <= pidx_d;
			bit_q <= bit_d;
			rem_q <= rem_d;
			quo_q <= quo_d;
			norm_q <= norm_d;
			nerr_q <= nerr_d;
		end
	end

	// ==========================================================
	// Per-producer normalized output with state
	logic [FRAC_W-1:0] normalized_output [N_PROD];
	sig_state_t        pstate [N_PROD];
	logic [CODE_W-1:0] pcode  [N_PROD];
	for (genvar p = 0; p < N_PROD; p++) begin : g_prod
		always_comb begin
			pstate[p] = sig_state_t'(prod_state_in[p*2 +: 2]);
			pcode[p] = prod_code_in[p*CODE_W +: CODE_W];
			if (pstate[p] == ST_VALID && !prod_disc_in[p] && nerr_q[p]) begin
				pstate[p] = ST_ERROR;
				pcode[p] = '1;
			end
			if (pstate[p] == ST_VALID || pstate[p] == ST_NA)
				pcode[p] = CODE_ZERO;
			if (prod_disc_in[p])
				normalized_output[p] = prod_raw_in[p*RAW_W] ? ONE_VAL : '0;
			else
				normalized_output[p] = norm_q[p];
		end
	end

	// ==========================================================
	// Consumer side: select, invert, threshold, restore
	logic [FRAC_W-1:0]        xn_d   [N_CONS];
	logic [RAW_W-1:0]         val_d  [N_CONS];
	logic                     bit_o_d [N_CONS];
	sig_state_t               cst_d  [N_CONS];
	logic [CODE_W-1:0]        ccode_d [N_CONS];
	logic [N_CONS*FRAC_W-1:0] xn_q;
	logic [N_CONS*RAW_W-1:0]  val_q;
	logic [N_CONS-1:0]        bit_o_q;
	logic [N_CONS*2-1:0]      cst_q;
	logic [N_CONS*CODE_W-1:0] ccode_q;
	logic [N_CONS-1:0]        cons_err;

	for (genvar c = 0; c < N_CONS; c++) begin : g_cons
		logic [FRAC_W+RAW_W-1:0] prod_w;
		logic [7:0]              src;
		always_comb begin
			// Selection lives only at the consumer; any producer
			src = csel_q[c] - 8'h1;
			prod_w = '0;
			if (csel_q[c] == SEL_NONE || int'(csel_q[c]) > N_PROD) begin
				xn_d[c] = '0;
				cst_d[c] = ST_NA;
				ccode_d[c] = CODE_ZERO;
			end else if (pstate[src[1:0]] != ST_VALID) begin
				xn_d[c] = '0;
				cst_d[c] = pstate[src[1:0]];
				ccode_d[c] = pcode[src[1:0]];
			end else begin
				cst_d[c] = ST_VALID;
				ccode_d[c] = CODE_ZERO;
				xn_d[c] = cinv_q[c] ? (ONE_VAL - normalized_output[src[1:0]]) : normalized_output[src[1:0]];
			end
			bit_o_d[c] = (cst_d[c] == ST_VALID) && (xn_d[c] >= HALF_VAL);
			prod_w = {{RAW_W{1'b0}}, xn_d[c]} * {{FRAC_W{1'b0}}, cmax_q[c] - cmin_q[c]};
			prod_w = prod_w + (prod_w >> FRAC_W) + (FRAC_W+RAW_W)'(1);
			if (cdisc_q[c])
				val_d[c] = RAW_W'(bit_o_d[c]);
			else
				val_d[c] = prod_w[FRAC_W+RAW_W-1:FRAC_W] + cmin_q[c];
			cons_err[c] = (cst_d[c] == ST_ERROR);
		end
	end

	always_ff @(posedge mclk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			xn_q <= '0;
			val_q <= '0;
			bit_o_q <= '0;
			cst_q <= {N_CONS{ST_NA}};
			ccode_q <= '0;
		end else if (clk_en_in) begin
			for (int c = 0; c < N_CONS; c++) begin
				xn_q[c*FRAC_W +: FRAC_W] <= xn_d[c];
				val_q[c*RAW_W +: RAW_W] <= val_d[c];
				bit_o_q[c] <= bit_o_d[c];
				cst_q[c*2 +: 2] <= cst_d[c];
				ccode_q[c*CODE_W +: CODE_W] <= ccode_d[c];
			end
		end
	end

	assign normalized_input_out = xn_q;
	assign cons_value_out = val_q;
	assign cons_bit_out = bit_o_q;
	assign cons_state_out = cst_q;
	assign cons_code_out = ccode_q;

	// ==========================================================
	// Register write, interrupt status and read data
	always_comb begin
		irq_st_d = irq_st_q;
		if (reg_wr_in && reg_addr_in == ADDR_IRQ_ST)
			irq_st_d = irq_st_q & ~reg_wdata_in[IRQ_W-1:0];
		if (round_done)
			irq_st_d[IRQ_NORM_DONE] = 1'b1;
		if (|cons_err)
			irq_st_d[IRQ_INPUT_ERR] = 1'b1;
		rdata_d = RST_ZERO;
		if (reg_rd_in) begin
			if (reg_addr_in == ADDR_IRQ_ST)
				rdata_d = 32'(irq_st_q);
			else if (reg_addr_in == ADDR_IRQ_MSK)
				rdata_d = 32'(irq_msk_q);
			else if (reg_addr_in == ADDR_STATUS)
				rdata_d = {24'h0, 5'h0, st_q};
			for (int i = 0; i < N_PROD; i++) begin
				if (hit(reg_addr_in, ADDR_PROD_B, 2*i))
					rdata_d = 32'(pmin_q[i]);
				if (hit(reg_addr_in, ADDR_PROD_B, 2*i+1))
					rdata_d = 32'(pmax_q[i]);
				if (hit(reg_addr_in, ADDR_RES_B, i))
					rdata_d = {15'h0, nerr_q[i], norm_q[i]};
			end
			for (int c = 0; c < N_CONS; c++) begin
				if (hit(reg_addr_in, ADDR_CONS_B, 3*c))
					rdata_d = {22'h0, cdisc_q[c], cinv_q[c], csel_q[c]};
				if (hit(reg_addr_in, ADDR_CONS_B, 3*c+1))
					rdata_d = 32'(cmin_q[c]);
				if (hit(reg_addr_in, ADDR_CONS_B, 3*c+2))
					rdata_d = 32'(cmax_q[c]);
			end
		end
	end

	always_ff @(posedge mclk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			irq_st_q <= '0;
			irq_msk_q <= '0;
			rdata_q <= RST_ZERO;
			irq_q <= 1'b0;
			pmin_q <= '{default: '0};
			pmax_q <= '{default: '1};
			csel_q <= '{default: SEL_NONE};
			cinv_q <= '{default: 1'b0};
			cdisc_q <= '{default: 1'b0};
			cmin_q <= '{default: '0};
			cmax_q <= '{default: '1};
		end else if (clk_en_in) begin
			irq_st_q <= irq_st_d;
			rdata_q <= rdata_d;
			irq_q <= |(irq_st_d & irq_msk_q);
			if (reg_wr_in && reg_addr_in == ADDR_IRQ_MSK)
				irq_msk_q <= reg_wdata_in[IRQ_W-1:0];
			for (int i = 0; i < N_PROD; i++) begin
				if (reg_wr_in && hit(reg_addr_in, ADDR_PROD_B, 2*i))
					pmin_q[i] <= reg_wdata_in[RAW_W-1:0];
				if (reg_wr_in && hit(reg_addr_in, ADDR_PROD_B, 2*i+1))
					pmax_q[i] <= reg_wdata_in[RAW_W-1:0];
			end
			for (int c = 0; c < N_CONS; c++) begin
				if (reg_wr_in && hit(reg_addr_in, ADDR_CONS_B, 3*c)) begin
					csel_q[c] <= reg_wdata_in[CONS_SEL_LSB +: 8];
					cinv_q[c] <= reg_wdata_in[CONS_INV_BIT];
					cdisc_q[c] <= reg_wdata_in[CONS_DISC_BIT];
				end
				if (reg_wr_in && hit(reg_addr_in, ADDR_CONS_B, 3*c+1))
					cmin_q[c] <= reg_wdata_in[RAW_W-1:0];
				if (reg_wr_in && hit(reg_addr_in, ADDR_CONS_B, 3*c+2))
					cmax_q[c] <= reg_wdata_in[RAW_W-1:0];
			end
		end
	end

	assign reg_rdata_out = rdata_q;
	assign irq_out = irq_q;

	// ==========================================================
	// Checks
	property p_na_zero;
		(clk_en_in && csel_q[0] == SEL_NONE && !cdisc_q[0]) |=> (cons_state_out[1:0] == ST_NA
			&& cons_value_out[RAW_W-1:0] == $past(cmin_q[0]) && normalized_input_out[FRAC_W-1:0] == '0);
	endproperty
	a_na_zero: assert property (p_na_zero) else $error("unconnected input not zero");
	property p_nonvalid_zero;
		(clk_en_in && cst_d[0] != ST_VALID) |=> (normalized_input_out[FRAC_W-1:0] == '0 && !cons_bit_out[0]);
	endproperty
	a_nonvalid_zero: assert property (p_nonvalid_zero) else $error("non-valid source not forced to zero");
	property p_threshold;
		(clk_en_in && cst_d[0] == ST_VALID) |=> (cons_bit_out[0] == (normalized_input_out[FRAC_W-1:0] >= HALF_VAL));
	endproperty
	a_threshold: assert property (p_threshold) else $error("half threshold wrong");
	property p_invert;
		(clk_en_in && cst_d[0] == ST_VALID && cinv_q[0])
			|=> (normalized_input_out[FRAC_W-1:0] == ONE_VAL - $past(normalized_output[g_cons[0].src[1:0]]));
	endproperty
	a_invert: assert property (p_invert) else $error("inversion wrong");
	property p_code;
		(cons_state_out[1:0] == ST_VALID || cons_state_out[1:0] == ST_NA) |-> cons_code_out[CODE_W-1:0] == CODE_ZERO;
	endproperty
	a_code: assert property (p_code) else $error("code not zero for valid or unavailable");
	property p_span_err;
		(clk_en_in && st_q == S_DIV && cur_span == '0) |=> nerr_q[$past(pidx_q[1:0])];
	endproperty
	a_span_err: assert property (p_span_err) else $error("zero span not flagged");
	property p_disc;
		(clk_en_in && cdisc_q[0]) |=> cons_value_out[RAW_W-1:0] == RAW_W'(cons_bit_out[0]);
	endproperty
	a_disc: assert property (p_disc) else $error("discrete input not 0 or 1");
	property p_irq;
		(clk_en_in && |(irq_st_d & irq_msk_q)) |=> irq_out;
	endproperty
	a_irq: assert property (p_irq) else $error("interrupt not raised");

endmodule
`default_nettype wire

// File: test/prod_model.sv
// Producer blocks that feed the router
`timescale 1ns/1ps
`default_nettype none
module prod_model
	import router_pkg::*;
(
	// Clock and reset
	input  wire logic          mclk_in,
	input  wire logic          sys_rst_in,
	// Update request
	input  wire logic          set_in,
	input  wire logic [1:0]    idx_in,
	input  wire logic [15:0]   raw_in,
	input  wire logic          disc_in,
	input  wire logic [1:0]    state_in,
	// Producer outputs
	output logic      [63:0]   prod_raw_out,
	output logic      [3:0]    prod_disc_out,
	output logic      [7:0]    prod_state_out,
	output logic      [127:0]  prod_code_out
);
	// ==========================================================
	// Producer registers
	always_ff @(posedge mclk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			prod_raw_out   <= '0;
			prod_disc_out  <= '0;
			prod_state_out <= 8'hFF;
			prod_code_out  <= '0;
		end else if (set_in) begin
			prod_raw_out[idx_in*16+:16] <= disc_in ? {15'h0000, raw_in[0]} : raw_in;
			prod_disc_out[idx_in]       <= disc_in;
			prod_state_out[idx_in*2+:2] <= state_in;
			prod_code_out[idx_in*32+:32] <= (state_in == ST_VALID || state_in == ST_NA) ? 32'h0000_0000
				: 32'hFFFF_FFFF;
		end
	end
endmodule
`default_nettype wire

// File: test/tb.sv
// Self-checking testbench for the signal router
`timescale 1ns/1ps
`default_nettype none
module tb;
	import router_pkg::*;
	logic          mclk_in = 1'b0;
	logic          sys_rst_in = 1'b1;
	logic          clk_en_in = 1'b1;
	logic [7:0]    reg_addr_in = 8'h00;
	logic [31:0]   reg_wdata_in = 32'h0000_0000;
	logic          reg_wr_in = 1'b0;
	logic          reg_rd_in = 1'b0;
	logic [31:0]   reg_rdata_out;
	logic          irq_out;
	logic          set_q = 1'b0;
	logic [1:0]    idx_q = 2'h0;
	logic [15:0]   raw_q = 16'h0000;
	logic          disc_q = 1'b0;
	logic [1:0]    st_q = 2'h0;
	logic [63:0]   p_raw;
	logic [3:0]    p_disc;
	logic [7:0]    p_state;
	logic [127:0]  p_code;
	logic [63:0]   c_norm;
	logic [63:0]   c_val;
	logic [3:0]    c_bit;
	logic [7:0]    c_state;
	logic [127:0]  c_code;
	logic [31:0]   rv;
	logic [1:0]    sts [3];
	int            fails = 0;
	int            samples_checked = 0;

	always #50 mclk_in = ~mclk_in;

	prod_model u_prod_model (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in), .set_in(set_q), .idx_in(idx_q),
		.raw_in(raw_q), .disc_in(disc_q), .state_in(st_q), .prod_raw_out(p_raw), .prod_disc_out(p_disc),
		.prod_state_out(p_state), .prod_code_out(p_code));

	signal_router u_signal_router (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in), .clk_en_in(clk_en_in),
		.prod_raw_in(p_raw), .prod_disc_in(p_disc), .prod_state_in(p_state), .prod_code_in(p_code),
		.normalized_input_out(c_norm), .cons_value_out(c_val), .cons_bit_out(c_bit),
		.cons_state_out(c_state), .cons_code_out(c_code), .reg_addr_in(reg_addr_in),
		.reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
		.reg_rdata_out(reg_rdata_out), .irq_out(irq_out));

	// ==========================================================
	// Tasks
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			fails++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk_in);
		reg_wr_in    <= 1'b1;
		reg_addr_in  <= a;
		reg_wdata_in <= d;
		@(posedge mclk_in);
		reg_wr_in <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a);
		@(posedge mclk_in);
		reg_rd_in   <= 1'b1;
		reg_addr_in <= a;
		@(posedge mclk_in);
		reg_rd_in <= 1'b0;
		#1;
		rv = reg_rdata_out;
	endtask

	task automatic pset(input logic [1:0] i, input logic [15:0] r, input logic d, input logic [1:0] s);
		@(posedge mclk_in);
		set_q  <= 1'b1;
		idx_q  <= i;
		raw_q  <= r;
		disc_q <= d;
		st_q   <= s;
		@(posedge mclk_in);
		set_q <= 1'b0;
	endtask

	task automatic settle();
		repeat (100) @(posedge mclk_in);
		#1;
	endtask

	task automatic cchk(input int c, input logic [15:0] n, input logic b, input logic [1:0] s,
		input logic [31:0] k);
		chk("cons_norm", {16'h0000, c_norm[c*16+:16]}, {16'h0000, n});
		chk("cons_bit", {31'h0, c_bit[c]}, {31'h0, b});
		chk("cons_state", {30'h0, c_state[c*2+:2]}, {30'h0, s});
		chk("cons_code", c_code[c*32+:32], k);
	endtask

	task automatic final_report();
		$display("checks %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	// ==========================================================
	// Watchdog
	initial begin
		repeat (20000) @(posedge mclk_in);
		fails++;
		final_report();
	end

	// ==========================================================
	// Tests
	initial begin
		sts = '{ST_SPECIAL, ST_NA, ST_ERROR};
		repeat (10) @(posedge mclk_in);
		sys_rst_in <= 1'b0;
		#1;
		chk("reset_state", {24'h0, c_state}, 32'h0000_00FF);
		rd(8'h05);
		chk("unmapped", rv, 32'h0000_0000);
		rd(8'h11);
		chk("prod0_max", rv, 32'h0000_FFFF);
		pset(2'h0, 16'h8000, 1'b0, ST_VALID);
		pset(2'h1, 16'h1000, 1'b0, ST_VALID);
		pset(2'h2, 16'h7FFF, 1'b0, ST_VALID);
		pset(2'h3, 16'h0001, 1'b1, ST_VALID);
		wr(8'h12, 32'h0000_1000);
		wr(8'h13, 32'h0000_1100);
		wr(8'h40, 32'h0000_0001);
		wr(8'h43, 32'h0000_0101);
		wr(8'h46, 32'h0000_0002);
		wr(8'h47, 32'h0000_0100);
		wr(8'h48, 32'h0000_0200);
		wr(8'h49, 32'h0000_0204);
		settle();
		cchk(0, 16'h8000, 1'b1, ST_VALID, 32'h0);
		chk("cons0_value", {16'h0, c_val[15:0]}, 32'h0000_8000);
		cchk(1, 16'h7FFF, 1'b0, ST_VALID, 32'h0);
		cchk(2, 16'h0000, 1'b0, ST_VALID, 32'h0);
		chk("cons2_value", {16'h0, c_val[47:32]}, 32'h0000_0100);
		chk("cons3_value", {16'h0, c_val[63:48]}, 32'h0000_0001);
		chk("cons3_bit", {31'h0, c_bit[3]}, 32'h1);
		rd(8'h80);
		chk("result0", rv, 32'h0000_8000);
		wr(8'h46, 32'h0000_0003);
		settle();
		cchk(2, 16'h7FFF, 1'b0, ST_VALID, 32'h0);
		foreach (sts[i]) begin
			pset(2'h0, 16'h8000, 1'b0, sts[i]);
			settle();
			cchk(1, 16'h0000, 1'b0, sts[i], (sts[i] == ST_NA) ? 32'h0 : 32'hFFFF_FFFF);
		end
		rd(8'h02);
		chk("irq_err", rv & 32'h2, 32'h2);
		chk("irq_masked", {31'h0, irq_out}, 32'h0);
		wr(8'h03, 32'h0000_0002);
		repeat (2) @(posedge mclk_in);
		#1;
		chk("irq_on", {31'h0, irq_out}, 32'h1);
		wr(8'h02, 32'h0000_0002);
		repeat (2) @(posedge mclk_in);
		#1;
		chk("irq_setwins", {31'h0, irq_out}, 32'h1);
		pset(2'h0, 16'h8000, 1'b0, ST_VALID);
		settle();
		wr(8'h02, 32'h0000_0002);
		repeat (2) @(posedge mclk_in);
		#1;
		chk("irq_off", {31'h0, irq_out}, 32'h0);
		wr(8'h13, 32'h0000_1000);
		wr(8'h46, 32'h0000_0002);
		settle();
		cchk(2, 16'h0000, 1'b0, ST_ERROR, 32'hFFFF_FFFF);
		rd(8'h81);
		chk("result1_err", rv & 32'h0001_0000, 32'h0001_0000);
		wr(8'h40, 32'h0000_0000);
		settle();
		cchk(0, 16'h0000, 1'b0, ST_NA, 32'h0);
		wr(8'h40, 32'h0000_0005);
		settle();
		cchk(0, 16'h0000, 1'b0, ST_NA, 32'h0);
		@(posedge mclk_in);
		clk_en_in <= 1'b0;
		pset(2'h0, 16'h0000, 1'b0, ST_VALID);
		settle();
		cchk(1, 16'h7FFF, 1'b0, ST_VALID, 32'h0);
		@(posedge mclk_in);
		clk_en_in <= 1'b1;
		settle();
		cchk(1, 16'hFFFF, 1'b1, ST_VALID, 32'h0);
		chk("cons1_value", {16'h0, c_val[31:16]}, 32'h0000_FFFF);
		wr(8'h40, 32'h0000_0301);
		settle();
		cchk(0, 16'hFFFF, 1'b1, ST_VALID, 32'h0);
		chk("cons0_disc", {16'h0, c_val[15:0]}, 32'h0000_0001);
		final_report();
	end
endmodule
`default_nettype wire
